/* core/bml_loader.sv */
// Boot-mode selection, bootstrap ROM and flash loader control.
// Assumes a flash macro with a ready/strobe port and a core that
// fetches from the ROM while boot_rom_sel is high.
`timescale 1ns/1ps

// Functional notes
// - Program-enable low at reset: core runs the 512x8 ROM, flash bypassed.
// - While the ROM runs, UART commands program the flash store.
// - Blank part is programmed only via the bootstrap loader over UART.
// - Programmed part upgrades via UART loader or USB write port.
// - Loader addresses the full 64k byte flash program store.
// - Synchroniser resets program-enable high, but no pull-up is modelled; the selection latches the synchronised pin, never the reset level.
module bml_loader
  import bml_pkg::*;
#(
  parameter logic [ROM_DEPTH-1:0][7:0] BOOT_IMAGE = '0
)
(
  // Clock, reset, enable
  input  wire logic                mclk,
  input  wire logic                rst_b,
  input  wire logic                ce,
  // Boot control pin
  input  wire logic                program_enable_n,
  // UART
  input  wire logic                uart_rxd,
  output logic                     uart_txd,
  // Boot selection and ROM fetch
  output logic                     boot_valid,
  output logic                     boot_rom_sel,
  input  wire logic [ROM_AW-1:0]   rom_addr,
  output logic [7:0]               rom_data,
  // Flash program store
  input  wire logic                flash_blank,
  input  wire logic                flash_ready,
  input  wire logic [7:0]          flash_rdata,
  output logic [FLASH_AW-1:0]      flash_addr,
  output logic [7:0]               flash_wdata,
  output logic                     flash_we,
  output logic                     flash_re,
  output logic                     flash_erase,
  // USB firmware upgrade port
  input  wire logic                usb_wr_valid,
  input  wire logic [FLASH_AW-1:0] usb_wr_addr,
  input  wire logic [7:0]          usb_wr_data,
  output logic                     usb_wr_ready
);

  // One register image; pe_s1 and pe_s2 are the pin synchroniser
  typedef struct packed {
    logic                pe_s1;
    logic                pe_s2;
    logic [1:0]          settle;
    logic                armed;
    logic                boot_sel;
    bml_state_e          state;
    logic                from_usb;
    logic [7:0]          cmd;
    logic [FLASH_AW-1:0] addr;
    logic [7:0]          wdata;
    logic [7:0]          resp;
    logic                tx_valid;
    logic [FLASH_AW-1:0] fl_addr;
    logic [7:0]          fl_wdata;
    logic                fl_we;
    logic                fl_re;
    logic                fl_erase;
    logic [7:0]          rom_q;
    logic                usb_ready;
  } bml_loader_s;

  bml_loader_s st_reg;
  bml_loader_s st_next;
  bml_byte_if  ubus ();

  // Commands and replies share one fixed-rate UART; no baud setting
  bml_uart u_uart (
    .mclk  (mclk),
    .rst_b (rst_b),
    .ce    (ce),
    .rxd   (uart_rxd),
    .txd   (uart_txd),
    .bus   (ubus.uart)
  );

  always_comb begin
    st_next = st_reg;
    st_next.pe_s1    = program_enable_n;
    st_next.pe_s2    = st_reg.pe_s1;
    st_next.fl_we    = 1'b0;
    st_next.fl_re    = 1'b0;
    st_next.fl_erase = 1'b0;
    st_next.usb_ready = 1'b0;

    // Sample only once the synchroniser holds the post-release pin level
    // Two edges fill the synchroniser, the third latches the selection
    if (!st_reg.armed) begin
      if (st_reg.settle == SETTLE_N) begin
        st_next.armed    = 1'b1;
        st_next.boot_sel = ~st_reg.pe_s2;
      end else begin
        st_next.settle = st_reg.settle + 2'h1;
      end
    end

    // ROM only serves fetches in boot mode; flash is bypassed then
    st_next.rom_q = st_reg.boot_sel ? BOOT_IMAGE[rom_addr] : BYTE_RST;

    unique case (st_reg.state)
      BML_IDLE: begin
        st_next.from_usb = 1'b0;
        if (st_reg.armed && st_reg.boot_sel && ubus.rx_valid) begin
          st_next.cmd = ubus.rx_data;
          if (ubus.rx_data == CMD_WRITE || ubus.rx_data == CMD_READ) begin
            st_next.state = BML_ADDR_HI;
          end else if (ubus.rx_data == CMD_ERASE) begin
            st_next.state = BML_FL_REQ;
          end else begin
            // Unknown codes are refused so the host never waits in vain
            st_next.resp     = RESP_NAK;
            st_next.tx_valid = 1'b1;
            st_next.state    = BML_SEND;
          end
        end else if (st_reg.usb_ready && usb_wr_valid) begin
          // Only a part that already holds firmware takes USB writes
          st_next.from_usb = 1'b1;
          st_next.cmd      = CMD_WRITE;
          st_next.addr     = usb_wr_addr;
          st_next.wdata    = usb_wr_data;
          st_next.state    = BML_FL_REQ;
        end else begin
          // Registered level; it falls the cycle after a request is taken
          st_next.usb_ready = st_reg.armed && !st_reg.boot_sel
                              && !flash_blank;
        end
      end
      BML_ADDR_HI: begin
        if (ubus.rx_valid) begin
          // Address arrives high byte first
          st_next.addr[15:8] = ubus.rx_data;
          st_next.state      = BML_ADDR_LO;
        end
      end
      BML_ADDR_LO: begin
        if (ubus.rx_valid) begin
          st_next.addr[7:0] = ubus.rx_data;
          st_next.state = (st_reg.cmd == CMD_READ) ? BML_FL_REQ : BML_DATA;
        end
      end
      BML_DATA: begin
        if (ubus.rx_valid) begin
          st_next.wdata = ubus.rx_data;
          st_next.state = BML_FL_REQ;
        end
      end
      BML_FL_REQ: begin
        if (flash_ready) begin
          // Copies stand on the flash port until the next strobe
          st_next.fl_addr  = st_reg.addr;
          st_next.fl_wdata = st_reg.wdata;
          st_next.fl_we    = (st_reg.cmd == CMD_WRITE);
          st_next.fl_re    = (st_reg.cmd == CMD_READ);
          st_next.fl_erase = (st_reg.cmd == CMD_ERASE);
          st_next.state    = BML_FL_WAIT;
        end
      end
      BML_FL_WAIT: begin
        if (flash_ready) begin
          // A read answers with the flash byte, not an acknowledge
          st_next.resp = (st_reg.cmd == CMD_READ) ? flash_rdata : RESP_ACK;
          if (st_reg.from_usb) begin
            st_next.state = BML_IDLE;
          end else begin
            st_next.tx_valid = 1'b1;
            st_next.state    = BML_SEND;
          end
        end
      end
      BML_SEND: begin
        // The UART takes the byte on the edge that clears tx_valid
        if (ubus.tx_ready) begin
          st_next.tx_valid = 1'b0;
          st_next.state    = BML_IDLE;
        end
      end
      default: begin
        st_next.state = BML_IDLE;
      end
    endcase
  end

  // Synchroniser resets high, but the pin replaces that level before the selection latches, so no pull-up is modelled
  // Clock enable low freezes every field, synchroniser included
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg       <= '0;
      st_reg.pe_s1 <= PE_RST;
      st_reg.pe_s2 <= PE_RST;
      st_reg.state <= BML_IDLE;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Every output is a register field, so none has a combinational path
  assign ubus.tx_valid = st_reg.tx_valid;
  assign ubus.tx_data  = st_reg.resp;
  assign boot_valid    = st_reg.armed;
  assign boot_rom_sel  = st_reg.boot_sel;
  assign rom_data      = st_reg.rom_q;
  assign flash_addr    = st_reg.fl_addr;
  assign flash_wdata   = st_reg.fl_wdata;
  assign flash_we      = st_reg.fl_we;
  assign flash_re      = st_reg.fl_re;
  assign flash_erase   = st_reg.fl_erase;
  assign usb_wr_ready  = st_reg.usb_ready;

endmodule

/* core/bml_pkg.sv */
// Package for the boot-mode select and firmware loader.
// Assumes a 10 MHz system clock and a UART at 115200 baud.
package bml_pkg;

  localparam int unsigned CLK_HZ    = 10_000_000;
  localparam int unsigned BAUD_RATE = 115200;
  localparam int unsigned BIT_CYC_I = CLK_HZ / BAUD_RATE;
  localparam logic [6:0]  BIT_CYC   = 7'(BIT_CYC_I - 1);
  localparam logic [6:0]  HALF_CYC  = 7'(BIT_CYC_I / 2 - 1);
  localparam logic [3:0]  LAST_BIT  = 4'h9;

  localparam int unsigned ROM_DEPTH = 512;
  localparam int unsigned ROM_AW    = 9;
  localparam int unsigned FLASH_AW  = 16;
  localparam logic [1:0]  SETTLE_N  = 2'h2;

  localparam logic [7:0] CMD_WRITE = 8'h57;
  localparam logic [7:0] CMD_READ  = 8'h52;
  localparam logic [7:0] CMD_ERASE = 8'h45;
  localparam logic [7:0] RESP_ACK  = 8'h06;
  localparam logic [7:0] RESP_NAK  = 8'h15;

  localparam logic       PE_RST    = 1'b1;
  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;

  typedef enum logic [2:0] {
    BML_IDLE, BML_ADDR_HI, BML_ADDR_LO, BML_DATA,
    BML_FL_REQ, BML_FL_WAIT, BML_SEND
  } bml_state_e;

endpackage

/* core/bml_byte_if.sv */
// Byte carrier between the loader engine and its UART.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface bml_byte_if;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       tx_valid;
  logic [7:0] tx_data;
  logic       tx_ready;

  modport uart (output rx_valid, output rx_data, output tx_ready,
                input tx_valid, input tx_data);
  modport eng  (input rx_valid, input rx_data, input tx_ready,
                output tx_valid, output tx_data);
endinterface

/* core/bml_uart.sv */
// 8N1 UART for the bootstrap loader, fixed rate.
// Assumes rxd already synchronous to mclk.
`timescale 1ns/1ps
module bml_uart
  import bml_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic ce,
  // Line
  input  wire logic rxd,
  output logic      txd,
  // Byte side
  bml_byte_if.uart  bus
);

  typedef struct packed {
    logic       rx_busy;
    logic [6:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       tx_busy;
    logic [6:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic       txd;
    logic       tx_ready;
  } bml_uart_s;

  bml_uart_s st_reg;
  bml_uart_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.rx_valid = 1'b0;
    if (!st_reg.rx_busy) begin
      if (!rxd) begin
        st_next.rx_busy = 1'b1;
        st_next.rx_cnt  = HALF_CYC;
        st_next.rx_bit  = 4'h0;
      end
    end else if (st_reg.rx_cnt != 7'h00) begin
      st_next.rx_cnt = st_reg.rx_cnt - 7'h01;
    end else begin
      st_next.rx_cnt = BIT_CYC;
      st_next.rx_bit = st_reg.rx_bit + 4'h1;
      if (st_reg.rx_bit == 4'h0) begin
        // A glitch shorter than half a bit is not a start bit
        st_next.rx_busy = ~rxd;
      end else if (st_reg.rx_bit == LAST_BIT) begin
        st_next.rx_busy  = 1'b0;
        st_next.rx_valid = rxd;
        st_next.rx_data  = st_reg.rx_sh;
      end else begin
        st_next.rx_sh = {rxd, st_reg.rx_sh[7:1]};
      end
    end

    if (!st_reg.tx_busy) begin
      if (bus.tx_valid && st_reg.tx_ready) begin
        st_next.tx_busy  = 1'b1;
        st_next.tx_ready = 1'b0;
        st_next.tx_sh    = {1'b1, bus.tx_data, 1'b0};
        st_next.tx_cnt   = BIT_CYC;
        st_next.tx_bit   = 4'h0;
        st_next.txd      = 1'b0;
      end
    end else if (st_reg.tx_cnt != 7'h00) begin
      st_next.tx_cnt = st_reg.tx_cnt - 7'h01;
    end else if (st_reg.tx_bit == LAST_BIT) begin
      st_next.tx_busy  = 1'b0;
      st_next.tx_ready = 1'b1;
      st_next.txd      = 1'b1;
    end else begin
      st_next.tx_cnt = BIT_CYC;
      st_next.tx_bit = st_reg.tx_bit + 4'h1;
      st_next.tx_sh  = {1'b1, st_reg.tx_sh[9:1]};
      st_next.txd    = st_reg.tx_sh[1];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg          <= '0;
      st_reg.txd      <= 1'b1;
      st_reg.tx_ready <= 1'b1;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign txd          = st_reg.txd;
  assign bus.rx_valid = st_reg.rx_valid;
  assign bus.rx_data  = st_reg.rx_data;
  assign bus.tx_ready = st_reg.tx_ready;

endmodule

/* verification/bml_host_model.sv */
// Host-side UART model: sends command bytes and decodes replies.
// Assumes mclk is the loader clock; bit time from the package rate.
`timescale 1ns/1ps
module bml_host_model
  import bml_pkg::*;
(
  // Clock
  input  wire logic  mclk,
  // Serial line
  output logic       rxd,
  input  wire logic  txd,
  // Decoded reply, one-cycle flag
  output logic       got,
  output logic [7:0] got_byte
);
  initial begin
    rxd = 1'b1;
    got = 1'b0;
    got_byte = 8'h00;
  end
  // 8N1, LSB first; line idles high between frames
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      #1 rxd = f[i];
      repeat (BIT_CYC_I - 1) @(posedge mclk);
    end
  endtask
  // Mid-bit sampling; a bad stop bit hides the byte and the bench times out
  always begin
    @(negedge txd);
    repeat (BIT_CYC_I / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC_I) @(posedge mclk);
      got_byte[i] = txd;
    end
    repeat (BIT_CYC_I) @(posedge mclk);
    got = txd;
    @(posedge mclk);
    #1 got = 1'b0;
  end
endmodule

/* verification/bml_loader_properties.sv */
// Checker for boot selection, flash strobes and the USB gate.
// Assumes it is bound to bml_loader and sees its ports only.
`timescale 1ns/1ps
module bml_loader_properties (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_b,
  // Watched ports
  input wire logic       program_enable_n,
  input wire logic       uart_txd,
  input wire logic       boot_valid,
  input wire logic       boot_rom_sel,
  input wire logic [7:0] rom_data,
  input wire logic       flash_we,
  input wire logic       flash_re,
  input wire logic       flash_erase,
  input wire logic       usb_wr_valid,
  input wire logic       usb_wr_ready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_valid_soon: assert property ($rose(rst_b) |-> ##[1:6] boot_valid)
    else $error("boot selection late");
  a_sel_from_pin: assert property ($rose(boot_valid) |->
    boot_rom_sel != program_enable_n) else $error("wrong boot selection");
  a_sel_held: assert property (boot_valid |=>
    boot_valid && $stable(boot_rom_sel)) else $error("selection moved");
  a_rom_bypass: assert property (!boot_rom_sel && !$past(boot_rom_sel)
    |-> rom_data == 8'h00) else $error("rom seen in run mode");
  a_run_tx_idle: assert property (!boot_rom_sel |-> uart_txd)
    else $error("reply in run mode");
  a_run_no_read: assert property ((flash_re || flash_erase)
    |-> boot_rom_sel) else $error("loader op in run mode");
  a_usb_gate: assert property ((boot_rom_sel || !boot_valid)
    |-> !usb_wr_ready) else $error("usb ready in boot mode");
  a_usb_take: assert property (usb_wr_valid && usb_wr_ready |=>
    !usb_wr_ready ##1 flash_we) else $error("usb write lost");
  a_we_pulse: assert property (flash_we |=> !flash_we)
    else $error("write strobe too long");
endmodule
bind bml_loader bml_loader_properties chk_i (.mclk, .rst_b,
  .program_enable_n, .uart_txd, .boot_valid, .boot_rom_sel, .rom_data,
  .flash_we, .flash_re, .flash_erase, .usb_wr_valid, .usb_wr_ready);

/* verification/tb_top.sv */
// Self-checking bench for the boot-mode loader.
// Assumes package, loader, host model and checker compiled first.
`timescale 1ns/1ps
module tb_top;
  import bml_pkg::*;
  function automatic logic [ROM_DEPTH-1:0][7:0] mk_img();
    for (int i = 0; i < ROM_DEPTH; i++) mk_img[i] = 8'(i * 7 + 3);
  endfunction
  localparam logic [ROM_DEPTH-1:0][7:0] IMG = mk_img();
  logic              mclk, rst_b, ce, program_enable_n, uart_rxd, uart_txd;
  logic              boot_valid, boot_rom_sel, flash_blank, flash_ready;
  logic              flash_we, flash_re, flash_erase, got, fast, took;
  logic              usb_wr_valid, usb_wr_ready;
  logic [ROM_AW-1:0] rom_addr;
  logic [7:0]        rom_data, flash_rdata, flash_wdata, usb_wr_data;
  logic [7:0]        got_byte, d;
  logic [15:0]       flash_addr, usb_wr_addr, a;
  logic [7:0]        mem [logic [15:0]];
  logic [31:0]       q [$];
  int                fail_count, check_count;
  bml_loader #(.BOOT_IMAGE(IMG)) bml_loader_i (.mclk, .rst_b, .ce,
    .program_enable_n, .uart_rxd, .uart_txd, .boot_valid, .boot_rom_sel,
    .rom_addr, .rom_data, .flash_blank, .flash_ready, .flash_rdata,
    .flash_addr, .flash_wdata, .flash_we, .flash_re, .flash_erase,
    .usb_wr_valid, .usb_wr_addr, .usb_wr_data, .usb_wr_ready);
  bml_host_model host_i (.mclk, .rxd(uart_rxd), .txd(uart_txd), .got,
    .got_byte);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Flash store: may hold ready low one cycle after any strobe
  always @(posedge mclk) begin
    #1;
    flash_ready = !(flash_we | flash_re | flash_erase) | fast;
    if (flash_we === 1'b1) mem[flash_addr] = flash_wdata;
    if (flash_re === 1'b1) flash_rdata = mem[flash_addr];
    fast = 1'($urandom_range(1, 0));
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h exp %h", $time, seen, exp);
    end
  endtask
  // An unexpected result meets an unknown note and so always mismatches
  task automatic see(input logic [31:0] v);
    if (q.size() == 0) chk(v, 32'hxxxx_xxxx);
    else chk(v, q.pop_front());
  endtask
  always @(negedge mclk) begin
    if (flash_we === 1'b1) see({8'h01, flash_addr, flash_wdata});
    if (flash_erase === 1'b1) see(32'h0300_0000);
    if (got === 1'b1) see({24'h02_0000, got_byte});
  end
  task automatic wait_empty();
    for (int i = 0; i < 3000 && q.size() > 0; i++) @(posedge mclk);
    if (q.size() > 0) begin
      fail_count++;
      end_sim();
    end
    #1;
  endtask
  // Pin first, then a reset pulse
  task automatic boot(input logic pin);
    program_enable_n = pin;
    rst_b = 1'b0;
    repeat (5) @(posedge mclk);
    #1 rst_b = 1'b1;
    repeat (8) @(posedge mclk);
    #1 chk(boot_valid, 1'b1);
    chk(boot_rom_sel, !pin);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] ad,
                     input logic [7:0] dt, input int n);
    host_i.send(c);
    if (n > 1) begin
      host_i.send(ad[15:8]);
      host_i.send(ad[7:0]);
    end
    if (n > 3) host_i.send(dt);
    wait_empty();
  endtask
  initial begin
    void'($urandom(32'h31a5));
    {rst_b, usb_wr_valid, flash_blank} = 3'b000;
    {ce, program_enable_n, flash_ready, fast} = 4'hf;
    {rom_addr, usb_wr_addr, usb_wr_data, flash_rdata} = '0;
    boot(1'b1);
    cmd(CMD_ERASE, 16'h0000, 8'h00, 1);
    repeat (1200) @(posedge mclk);
    #1 usb_wr_addr = 16'($urandom);
    usb_wr_data = 8'($urandom);
    q.push_back({8'h01, usb_wr_addr, usb_wr_data});
    usb_wr_valid = 1'b1;
    took = 1'b0;
    for (int i = 0; i < 50 && !took; i++) begin
      @(posedge mclk);
      took = (usb_wr_ready === 1'b1);
    end
    #1 usb_wr_valid = 1'b0;
    chk(took, 1'b1);
    wait_empty();
    flash_blank = 1'b1;
    repeat (20) @(posedge mclk);
    #1 chk(usb_wr_ready, 1'b0);
    boot(1'b0);
    program_enable_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      rom_addr = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : 9'($urandom);
      repeat (2) @(posedge mclk);
      #1 chk(rom_data, IMG[rom_addr]);
    end
    // Clock enable low must freeze the ROM output register
    ce = 1'b0;
    rom_addr = ~rom_addr;
    repeat (2) @(posedge mclk);
    #1 chk(rom_data, IMG[~rom_addr]);
    ce = 1'b1;
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
      d = 8'($urandom);
      q.push_back({8'h01, a, d});
      q.push_back({24'h02_0000, RESP_ACK});
      cmd(CMD_WRITE, a, d, 4);
      q.push_back({24'h02_0000, d});
      cmd(CMD_READ, a, 8'h00, 3);
    end
    q.push_back(32'h0300_0000);
    q.push_back({24'h02_0000, RESP_ACK});
    cmd(CMD_ERASE, 16'h0000, 8'h00, 1);
    q.push_back({24'h02_0000, RESP_NAK});
    cmd(8'h33, 16'h0000, 8'h00, 1);
    boot(1'b1);
    end_sim();
  end
endmodule
